// ==== bench/speed_reference_selector_props.sv ====
// Bus timing and selector output properties
`timescale 1ns/10ps
`default_nettype none
module sel_props (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, low
    input wire logic awvalid, // aw valid
    input wire logic awready, // aw ready
    input wire logic wvalid, // w valid
    input wire logic wready, // w ready
    input wire logic bvalid, // b valid
    input wire logic arvalid, // ar valid
    input wire logic arready, // ar ready
    input wire logic rvalid, // r valid
    input wire logic [1:0] drive_state, // state
    input wire logic [31:0] active_reference, // reference
    input wire logic [2:0] active_source_indicator, // source
    input wire logic [3:0] active_preset_indicator, // preset
    input wire logic jog_forward, // jog
    input wire logic [4:0] sequencing_control_bits, // bits
    input wire logic sequencing_enable_bit // enable
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_reset_zero;
        disable iff (1'b0) !aresetn |=> active_reference == 32'h0 && active_source_indicator == 3'h0;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("outputs not cleared");
    property p_write_answer;
        awvalid && awready && wvalid && wready |-> ##2 bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write answer late");
    property p_aw_refuse;
        awvalid && awready |=> !awready [*2];
    endproperty
    a_aw_refuse: assert property (p_aw_refuse) else $error("second write taken early");
    property p_read_answer;
        arvalid && arready |=> rvalid && !arready;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer late");
    property p_keypad_gate;
        active_source_indicator == 3'h4 |-> sequencing_control_bits == 5'h0 && !sequencing_enable_bit && !jog_forward;
    endproperty
    a_keypad_gate: assert property (p_keypad_gate) else $error("keypad mode not gated");
    property p_no_preset;
        active_source_indicator inside {3'h4, 3'h5, 3'h6} |-> active_preset_indicator == 4'h0;
    endproperty
    a_no_preset: assert property (p_no_preset) else $error("preset shown in keypad mode");
    property p_jog_state;
        $rose(jog_forward) |-> $past(drive_state) != 2'h3;
    endproperty
    a_jog_state: assert property (p_jog_state) else $error("jog taken while running");
    property p_preset_range;
        active_source_indicator == 3'h3 |-> active_preset_indicator inside {[4'h1:4'h8]};
    endproperty
    a_preset_range: assert property (p_preset_range) else $error("preset out of range");
    property p_fraction;
        active_source_indicator != 3'h5 |-> active_reference[15:0] == 16'h0;
    endproperty
    a_fraction: assert property (p_fraction) else $error("fraction outside precision");
endmodule // sel_props
bind speed_reference_selector sel_props u_sel_props (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
    .bvalid, .arvalid, .arready, .rvalid, .drive_state, .active_reference, .active_source_indicator,
    .active_preset_indicator, .jog_forward, .sequencing_control_bits, .sequencing_enable_bit);
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the speed reference selector
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int UNIT = 4;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, terminal_input_a = 1'b0, terminal_input_b = 1'b0;
    logic keypad_run_key = 1'b0, keypad_stop_key = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, active_reference, r;
    logic [3:0] wstrb = 4'hf, active_preset_indicator;
    logic [15:0] analog_input_1 = 16'h0, analog_input_2 = 16'h0, kp, crs, fin;
    logic [15:0] pre [8];
    logic [1:0] drive_state = 2'h0, bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, jog_forward, run_request, sequencing_enable_bit;
    logic [2:0] active_source_indicator;
    logic [4:0] sequencing_control_bits;
    logic [38:0] outs;
    int mismatches = 0, compares = 0, seed = 80, k, n, last;
    assign outs = {active_source_indicator, active_preset_indicator, active_reference};
    speed_reference_selector #(.SCAN_UNIT_CYCLES(UNIT)) u_speed_reference_selector (.aclk, .aresetn, .awaddr,
        .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .analog_input_1, .analog_input_2, .drive_state,
        .terminal_input_a, .terminal_input_b, .keypad_run_key, .keypad_stop_key, .active_reference,
        .active_source_indicator, .active_preset_indicator, .jog_forward, .run_request,
        .sequencing_control_bits, .sequencing_enable_bit);
    always #20 aclk = ~aclk;
    task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tmo(input int c);
        if (c >= 60)
        begin
            mismatches++;
            give_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int c = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            c++;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid && c < 60);
        tmo(c);
        chk("bresp", bresp, er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int c = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            c++;
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid && c < 60);
        tmo(c);
        chk("rdata", {rresp, rdata}, {er, ed});
    endtask
    function automatic logic [38:0] model(input int m, input int s);
        int bs, p;
        logic [15:0] bv;
        if (m == 4 || m == 6)
            return {m[2:0], 4'h0, kp, 16'h0};
        if (m == 5)
            return {3'h5, 4'h0, crs, fin};
        bs = (m == 3) ? 3 : (m == 2 || (m == 0 && terminal_input_a)) ? 2 : 1;
        p = (s == 0 && m != 0) ? 1 + {terminal_input_b, terminal_input_a} : (s < 2) ? 1 : s;
        bv = (bs == 2) ? analog_input_2 : analog_input_1;
        if (p > 1 || m == 3)
            bv = pre[p - 1];
        return {bs[2:0], p[3:0], bv, 16'h0};
    endfunction
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h00, 32'h0, 2'h0);
        rd(8'h04, 32'h0, 2'h0);
        rd(8'h08, 32'h1, 2'h0);
        for (k = 0; k < 8; k++)
        begin
            r = $random(seed);
            pre[k] = r[15:0];
            wr(8'h40 + 8'(k * 4), {16'h0, pre[k]}, 2'h0);
        end
        for (k = 0; k < 8; k++)
            rd(8'h40 + 8'(k * 4), {16'h0, pre[k]}, 2'h0);
        r = $random(seed);
        kp = r[15:0];
        crs = r[31:16];
        fin = r[15:0] ^ 16'hc3c3;
        wr(8'h0c, {16'h0, kp}, 2'h0);
        wr(8'h10, {16'h0, crs}, 2'h0);
        wr(8'h14, {16'h0, fin}, 2'h0);
        rd(8'h30, 32'h0, 2'h2);
        wr(8'h1c, 32'h3ff, 2'h0);
        rd(8'h1c, 32'h11, 2'h0);
        for (k = 0; k < 56; k++)
        begin
            r = $random(seed);
            analog_input_1 <= r[31:16];
            analog_input_2 <= r[15:0] ^ 16'h5a5a;
            terminal_input_a <= r[8];
            terminal_input_b <= r[9];
            wr(8'h00, k % 7, 2'h0);
            wr(8'h04, r[7:4] % 9, 2'h0);
            repeat (8) @(posedge aclk);
            chk("selection", outs, model(k % 7, r[7:4] % 9));
        end
        terminal_input_a <= 1'b0;
        terminal_input_b <= 1'b0;
        wr(8'h04, 32'h0, 2'h0);
        wr(8'h08, 32'h2, 2'h0);
        wr(8'h00, 32'h1, 2'h0);
        wr(8'h04, 32'h9, 2'h0);
        for (k = 0; k < 10; k++)
        begin
            n = 0;
            last = active_preset_indicator;
            while (active_preset_indicator == last && n < 60)
            begin
                @(posedge aclk);
                n++;
            end
            tmo(n);
            if (k > 0)
                chk("scan_hold", n, 2 * UNIT);
            chk("scan_step", active_preset_indicator, last % 8 + 1);
            chk("scan_ref", outs, model(1, active_preset_indicator));
        end
        wr(8'h04, 32'h0, 2'h0);
        wr(8'h18, 32'h3f, 2'h0);
        wr(8'h00, 32'h4, 2'h0);
        terminal_input_b <= 1'b1;
        keypad_run_key <= 1'b1;
        repeat (8) @(posedge aclk);
        chk("keypad_run", {sequencing_control_bits, sequencing_enable_bit, jog_forward, run_request}, 8'h01);
        keypad_stop_key <= 1'b1;
        repeat (8) @(posedge aclk);
        chk("keypad_stop", run_request, 1'b0);
        terminal_input_b <= 1'b0;
        wr(8'h00, 32'h6, 2'h0);
        for (k = 0; k < 4; k++)
        begin
            drive_state <= k[1:0];
            terminal_input_b <= 1'b1;
            repeat (8) @(posedge aclk);
            chk("jog", jog_forward, k != 3);
            terminal_input_b <= 1'b0;
            repeat (8) @(posedge aclk);
        end
        give_verdict();
    end
endmodule // tb
`default_nettype wire

// ==== include/scan_if.sv ====
// Link between the selector and its preset scan timer
`timescale 1ns/10ps
`default_nettype none
interface scan_if;
    logic enable;
    logic [15:0] interval;
    logic [2:0] step;
    modport timer (input enable, input interval, output step);
    modport user (output enable, output interval, input step);
endinterface
`default_nettype wire

// ==== include/speed_ref_pkg.sv ====
// Constants and types shared by the speed reference selector files
package speed_ref_pkg;
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned SCAN_UNIT_NS = 1000000;
    localparam int unsigned SCAN_UNIT_CYCLES = SCAN_UNIT_NS / CLK_PERIOD_NS;

    localparam logic [7:0] OFS_SOURCE = 8'h00;
    localparam logic [7:0] OFS_PRESET_CTL = 8'h04;
    localparam logic [7:0] OFS_INTERVAL = 8'h08;
    localparam logic [7:0] OFS_KEYPAD = 8'h0c;
    localparam logic [7:0] OFS_COARSE = 8'h10;
    localparam logic [7:0] OFS_FINE = 8'h14;
    localparam logic [7:0] OFS_SEQ = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_ACTIVE = 8'h20;
    localparam logic [7:0] OFS_PRESET_BASE = 8'h40;
    localparam logic [7:0] OFS_PRESET_LAST = 8'h5c;

    localparam logic [2:0] RST_SOURCE = 3'h0;
    localparam logic [3:0] RST_PRESET_CTL = 4'h0;
    localparam logic [15:0] RST_INTERVAL = 16'h0001;

    localparam int unsigned SEQ_EN_BIT = 5;
    localparam int unsigned STAT_SRC_LSB = 0;
    localparam int unsigned STAT_PRESET_LSB = 4;
    localparam int unsigned STAT_JOG_BIT = 8;
    localparam int unsigned STAT_RUN_BIT = 9;

    localparam logic [3:0] PRESET_SCAN = 4'h9;
    localparam logic [3:0] PRESET_FIRST = 4'h1;
    localparam logic [3:0] PRESET_MAX = 4'h8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SRC_DUAL_ANALOG = 3'h0,
        SRC_ANALOG_ONE_PRESETS = 3'h1,
        SRC_ANALOG_TWO_PRESETS = 3'h2,
        SRC_PRESETS_ONLY = 3'h3,
        SRC_KEYPAD = 3'h4,
        SRC_PRECISION = 3'h5,
        SRC_KEYPAD_REF = 3'h6
    } source_mode_t;

    typedef enum logic [1:0] {
        DRV_READY = 2'h0,
        DRV_INHIBIT = 2'h1,
        DRV_TRIP = 2'h2,
        DRV_RUN = 2'h3
    } drive_state_t;
endpackage

// ==== rtl/preset_scan_timer.sv ====
// Preset scan timer: steps through eight references at a set interval
`timescale 1ns/10ps
`default_nettype none
module preset_scan_timer #(
    parameter int unsigned UNIT_CYCLES = speed_ref_pkg::SCAN_UNIT_CYCLES
) (
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    scan_if.timer scan // enable, interval in, step out
);
    typedef struct packed {
        logic [31:0] prescale;
        logic [15:0] units;
        logic [2:0] step;
    } timer_state_t;

    timer_state_t s;
    timer_state_t next_s;
    logic [15:0] last_unit;

    always_comb
    begin
        next_s = s;
        // Zero interval behaves as one unit so the scan never stalls
        last_unit = (scan.interval == 16'h0000) ? 16'h0000 : scan.interval - 16'h0001;
        if (!scan.enable)
        begin
            next_s = '0;
        end
        else if (s.prescale >= UNIT_CYCLES - 1)
        begin
            next_s.prescale = '0;
            if (s.units >= last_unit) // see R3
            begin
                next_s.units = '0;
                next_s.step = s.step + 3'h1; // see R2
            end
            else
            begin
                next_s.units = s.units + 16'h0001;
            end
        end
        else
        begin
            next_s.prescale = s.prescale + 32'h1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s <= '0;
        else
            s <= next_s;
    end

    assign scan.step = s.step;
endmodule // preset_scan_timer
`default_nettype wire

// ==== rtl/speed_reference_selector.sv ====
// Speed reference selector with AXI4-Lite register access
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Function
// R1: selector value 9 starts the scan timer
// R2: scan base reference, then presets 2 to 8
// R3: each scanned reference held one interval
// R4: eight stored preset values kept
// R5: analog modes, selector 2-8 forces preset
// R6: presets mode, selector 1-8 picks preset
// R7: keypad mode uses keypad value and keys
// R8: keypad mode ignores sequencing bits, no jog
// R9: precision mode joins coarse and fine
// R10: selector 0, terminals pick base or 2-4
// R11: dual analog, terminal a picks analog
// R12: jog taken only in ready, inhibit, trip
module speed_reference_selector #(
    parameter int unsigned SCAN_UNIT_CYCLES = speed_ref_pkg::SCAN_UNIT_CYCLES
) (
    input wire logic aclk, // system clock, 25 MHz
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [7:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // write byte strobes
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [7:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    input wire logic [15:0] analog_input_1, // first analog reference
    input wire logic [15:0] analog_input_2, // second analog reference
    input wire logic [1:0] drive_state, // run sequencer state
    input wire logic terminal_input_a, // digital terminal, pin
    input wire logic terminal_input_b, // digital terminal, pin
    input wire logic keypad_run_key, // keypad run key, pin
    input wire logic keypad_stop_key, // keypad stop key, pin
    output logic [31:0] active_reference, // integer high half, fraction low
    output logic [2:0] active_source_indicator, // source in use
    output logic [3:0] active_preset_indicator, // preset in use, 0 if none
    output logic jog_forward, // jog forward command
    output logic run_request, // run command to sequencer
    output logic [4:0] sequencing_control_bits, // gated sequencing bits
    output logic sequencing_enable_bit // gated sequencing enable
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_got;
        logic w_got;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [2:0] source;
        logic [3:0] preset_sel;
        logic [15:0] interval;
        logic [15:0] keypad;
        logic [15:0] coarse;
        logic [15:0] fine;
        logic [5:0] seq;
        logic [7:0][15:0] presets;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] sync3;
        logic [3:0] pins;
        logic [3:0] pins_prev;
        logic kp_run;
        logic jog;
        logic run_req;
        logic [4:0] seq_out;
        logic seq_en_out;
        logic [31:0] reference;
        logic [2:0] src_ind;
        logic [3:0] preset_ind;
    } selector_state_t;

    selector_state_t s;
    selector_state_t next_s;
    scan_if scan ();

    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr[1:0] == 2'h0) &&
            ((addr <= speed_ref_pkg::OFS_ACTIVE) ||
             (addr >= speed_ref_pkg::OFS_PRESET_BASE && addr <= speed_ref_pkg::OFS_PRESET_LAST));
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++)
            merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
    endfunction

    function automatic logic is_preset_mode(input speed_ref_pkg::source_mode_t m);
        is_preset_mode = (m == speed_ref_pkg::SRC_DUAL_ANALOG) ||
            (m == speed_ref_pkg::SRC_ANALOG_ONE_PRESETS) ||
            (m == speed_ref_pkg::SRC_ANALOG_TWO_PRESETS) ||
            (m == speed_ref_pkg::SRC_PRESETS_ONLY);
    endfunction

    // Preset number 1..8, or 0 outside the preset modes, where 1 means the mode's base reference
    function automatic logic [3:0] pick_preset(input speed_ref_pkg::source_mode_t m,
                                               input logic [3:0] sel, input logic a,
                                               input logic b, input logic [2:0] step);
        logic [3:0] code;
        code = {2'h0, b, a} + 4'h1;
        pick_preset = speed_ref_pkg::PRESET_FIRST;
        if (!is_preset_mode(m))
            pick_preset = 4'h0;
        else if (sel == speed_ref_pkg::PRESET_SCAN)
            pick_preset = {1'b0, step} + 4'h1; // see R1
        else if (sel == 4'h0 && m != speed_ref_pkg::SRC_DUAL_ANALOG)
            pick_preset = code; // see R10
        else if (sel >= 4'h2 && sel <= speed_ref_pkg::PRESET_MAX)
            pick_preset = sel; // see R5
        else if (sel == 4'h1 && m == speed_ref_pkg::SRC_PRESETS_ONLY)
            pick_preset = sel; // see R6
    endfunction

    speed_ref_pkg::source_mode_t mode;
    logic [3:0] sel_eff;
    logic [3:0] preset_idx;
    logic [15:0] base_ref;
    logic [2:0] src_code;
    logic keypad_mode;
    logic jog_mode;
    logic jog_state_ok;
    logic wr_fire;
    logic [31:0] wr_old;
    logic [31:0] wr_word;
    logic [31:0] rd_word;

    assign scan.enable = is_preset_mode(mode) && (sel_eff == speed_ref_pkg::PRESET_SCAN); // see R1
    assign scan.interval = s.interval; // see R3

    preset_scan_timer #(
        .UNIT_CYCLES(SCAN_UNIT_CYCLES)
    ) u_scan (
        .aclk(aclk),
        .aresetn(aresetn),
        .scan(scan.timer)
    );

    always_comb
    begin
        next_s = s;
        // Code 7 has no meaning; it falls back to the reset mode
        if (s.source == 3'h7)
            mode = speed_ref_pkg::SRC_DUAL_ANALOG;
        else
            mode = speed_ref_pkg::source_mode_t'(s.source);
        sel_eff = (s.preset_sel > speed_ref_pkg::PRESET_SCAN) ? 4'h0 : s.preset_sel;
        keypad_mode = (mode == speed_ref_pkg::SRC_KEYPAD);

        // Pin synchroniser; a level counts once stages two and three agree
        next_s.sync1 = {keypad_stop_key, keypad_run_key, terminal_input_b, terminal_input_a};
        next_s.sync2 = s.sync1;
        next_s.sync3 = s.sync2;
        next_s.pins = (~(s.sync2 ^ s.sync3) & s.sync3) | ((s.sync2 ^ s.sync3) & s.pins);
        next_s.pins_prev = s.pins;

        // Base reference of each mode
        unique case (mode)
            speed_ref_pkg::SRC_DUAL_ANALOG:
            begin
                base_ref = s.pins[0] ? analog_input_2 : analog_input_1; // see R11
                src_code = s.pins[0] ? 3'h2 : 3'h1; // see R11
            end
            speed_ref_pkg::SRC_ANALOG_ONE_PRESETS:
            begin
                base_ref = analog_input_1;
                src_code = 3'h1;
            end
            speed_ref_pkg::SRC_ANALOG_TWO_PRESETS:
            begin
                base_ref = analog_input_2;
                src_code = 3'h2;
            end
            speed_ref_pkg::SRC_PRESETS_ONLY:
            begin
                base_ref = s.presets[0];
                src_code = 3'h3;
            end
            speed_ref_pkg::SRC_KEYPAD, speed_ref_pkg::SRC_PRECISION, speed_ref_pkg::SRC_KEYPAD_REF:
            begin
                base_ref = s.keypad;
                src_code = s.source;
            end
        endcase

        preset_idx = pick_preset(mode, sel_eff, s.pins[0], s.pins[1], scan.step);
        next_s.src_ind = src_code;
        next_s.preset_ind = preset_idx;
        unique case (mode)
            speed_ref_pkg::SRC_KEYPAD, speed_ref_pkg::SRC_KEYPAD_REF:
                next_s.reference = {s.keypad, 16'h0000}; // see R7
            speed_ref_pkg::SRC_PRECISION:
                next_s.reference = {s.coarse, s.fine}; // see R9
            default:
            begin
                if (preset_idx == speed_ref_pkg::PRESET_FIRST)
                    next_s.reference = {base_ref, 16'h0000};
                else
                    next_s.reference = {s.presets[3'(preset_idx - 4'h1)], 16'h0000}; // see R4
            end
        endcase

        // Keypad keys drive the run latch; stop wins over run
        if (!keypad_mode)
            next_s.kp_run = 1'b0;
        else if (s.pins[3] && !s.pins_prev[3])
            next_s.kp_run = 1'b0; // see R7
        else if (s.pins[2] && !s.pins_prev[2])
            next_s.kp_run = 1'b1; // see R7
        next_s.run_req = keypad_mode ? s.kp_run : (s.seq[speed_ref_pkg::SEQ_EN_BIT] & s.seq[0]);
        next_s.seq_out = keypad_mode ? 5'h00 : s.seq[4:0]; // see R8
        next_s.seq_en_out = keypad_mode ? 1'b0 : s.seq[speed_ref_pkg::SEQ_EN_BIT]; // see R8

        // Jog is sampled on the request edge, then held while the pin stays high
        jog_mode = (mode == speed_ref_pkg::SRC_DUAL_ANALOG) || (mode == speed_ref_pkg::SRC_KEYPAD_REF);
        jog_state_ok = (drive_state != speed_ref_pkg::DRV_RUN);
        if (!jog_mode || !s.pins[1])
            next_s.jog = 1'b0; // see R8
        else if (!s.pins_prev[1] && jog_state_ok)
            next_s.jog = 1'b1; // see R12

        // Write channel: address and data taken in either order
        if (awvalid && s.awready)
        begin
            next_s.waddr = awaddr;
            next_s.aw_got = 1'b1;
            next_s.awready = 1'b0;
        end
        if (wvalid && s.wready)
        begin
            next_s.wdata = wdata;
            next_s.wstrb = wstrb;
            next_s.w_got = 1'b1;
            next_s.wready = 1'b0;
        end
        wr_fire = s.aw_got && s.w_got && !s.bvalid;
        unique case (s.waddr)
            speed_ref_pkg::OFS_SOURCE: wr_old = {29'h0, s.source};
            speed_ref_pkg::OFS_PRESET_CTL: wr_old = {28'h0, s.preset_sel};
            speed_ref_pkg::OFS_INTERVAL: wr_old = {16'h0, s.interval};
            speed_ref_pkg::OFS_KEYPAD: wr_old = {16'h0, s.keypad};
            speed_ref_pkg::OFS_COARSE: wr_old = {16'h0, s.coarse};
            speed_ref_pkg::OFS_FINE: wr_old = {16'h0, s.fine};
            speed_ref_pkg::OFS_SEQ: wr_old = {26'h0, s.seq};
            default: wr_old = {16'h0, s.presets[s.waddr[4:2]]};
        endcase
        wr_word = merge(wr_old, s.wdata, s.wstrb);
        if (wr_fire)
        begin
            next_s.bvalid = 1'b1;
            next_s.bresp = is_mapped(s.waddr) ? speed_ref_pkg::RESP_OKAY : speed_ref_pkg::RESP_SLVERR;
            if (s.waddr >= speed_ref_pkg::OFS_PRESET_BASE && is_mapped(s.waddr))
                next_s.presets[s.waddr[4:2]] = wr_word[15:0]; // see R4
            else
            begin
                unique case (s.waddr)
                    speed_ref_pkg::OFS_SOURCE: next_s.source = wr_word[2:0];
                    speed_ref_pkg::OFS_PRESET_CTL: next_s.preset_sel = wr_word[3:0];
                    speed_ref_pkg::OFS_INTERVAL: next_s.interval = wr_word[15:0];
                    speed_ref_pkg::OFS_KEYPAD: next_s.keypad = wr_word[15:0];
                    speed_ref_pkg::OFS_COARSE: next_s.coarse = wr_word[15:0];
                    speed_ref_pkg::OFS_FINE: next_s.fine = wr_word[15:0];
                    speed_ref_pkg::OFS_SEQ: next_s.seq = wr_word[5:0];
                    default: next_s.seq = s.seq;
                endcase
            end
        end
        if (s.bvalid && bready)
        begin
            next_s.bvalid = 1'b0;
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
        end
        // Ready flags reopen only once the response is gone
        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready = !next_s.w_got && !next_s.bvalid;

        // Read channel: one read in flight, data one cycle after the address
        unique case (araddr)
            speed_ref_pkg::OFS_SOURCE: rd_word = {29'h0, s.source};
            speed_ref_pkg::OFS_PRESET_CTL: rd_word = {28'h0, s.preset_sel};
            speed_ref_pkg::OFS_INTERVAL: rd_word = {16'h0, s.interval};
            speed_ref_pkg::OFS_KEYPAD: rd_word = {16'h0, s.keypad};
            speed_ref_pkg::OFS_COARSE: rd_word = {16'h0, s.coarse};
            speed_ref_pkg::OFS_FINE: rd_word = {16'h0, s.fine};
            speed_ref_pkg::OFS_SEQ: rd_word = {26'h0, s.seq};
            speed_ref_pkg::OFS_STATUS:
            begin
                rd_word = '0;
                rd_word[speed_ref_pkg::STAT_SRC_LSB +: 3] = s.src_ind;
                rd_word[speed_ref_pkg::STAT_PRESET_LSB +: 4] = s.preset_ind;
                rd_word[speed_ref_pkg::STAT_JOG_BIT] = s.jog;
                rd_word[speed_ref_pkg::STAT_RUN_BIT] = s.run_req;
            end
            speed_ref_pkg::OFS_ACTIVE: rd_word = s.reference;
            default: rd_word = is_mapped(araddr) ? {16'h0, s.presets[araddr[4:2]]} : 32'h0;
        endcase
        if (arvalid && s.arready)
        begin
            next_s.arready = 1'b0;
            next_s.rvalid = 1'b1;
            next_s.rdata = rd_word;
            next_s.rresp = is_mapped(araddr) ? speed_ref_pkg::RESP_OKAY : speed_ref_pkg::RESP_SLVERR;
        end
        else if (s.rvalid && rready)
        begin
            next_s.rvalid = 1'b0;
            next_s.arready = 1'b1;
        end
        else if (!s.rvalid)
        begin
            next_s.arready = 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0;
            s.source <= speed_ref_pkg::RST_SOURCE;
            s.preset_sel <= speed_ref_pkg::RST_PRESET_CTL;
            s.interval <= speed_ref_pkg::RST_INTERVAL;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign awready = s.awready;
    assign wready = s.wready;
    assign bresp = s.bresp;
    assign bvalid = s.bvalid;
    assign arready = s.arready;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign rvalid = s.rvalid;
    assign active_reference = s.reference;
    assign active_source_indicator = s.src_ind;
    assign active_preset_indicator = s.preset_ind;
    assign jog_forward = s.jog;
    assign run_request = s.run_req;
    assign sequencing_control_bits = s.seq_out;
    assign sequencing_enable_bit = s.seq_en_out;
endmodule // speed_reference_selector
`default_nettype wire
